// ---- core/exc_pkg.sv ----
// Shared constants for the exception prioritizer
`default_nettype none
package exc_pkg;
  localparam int          NUM_CAUSES   = 14;
  localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;
  localparam logic [31:0] DEBUG_VECTOR = 32'hBFC0_0480;
  localparam logic [31:0] GENERAL_OFS  = 32'h0000_0180;
  localparam logic [31:0] EXCEPTION_BASE_ADDRESS_RESET  = 32'h8000_0000;
  localparam logic [4:0]  CODE_INT     = 5'h00;
  localparam logic [4:0]  CODE_TLB_FETCH_MISS    = 5'h02;
  localparam logic [4:0]  CODE_FETCH_ADDRESS_ERROR    = 5'h04;
  localparam logic [4:0]  CODE_IBE     = 5'h06;
  localparam logic [4:0]  CODE_XI      = 5'h14;
  localparam logic [4:0]  CODE_WATCH   = 5'h17;
  localparam logic [4:0]  CODE_MCHK    = 5'h18;
  // Cause indices, highest rank first
  localparam int C_RST  = 0;
  localparam int C_SRST = 1;
  localparam int C_DSS  = 2;
  localparam int C_DEBUG_INTERRUPT = 3;
  localparam int C_NMI  = 4;
  localparam int C_MCHK = 5;
  localparam int C_INT  = 6;
  localparam int C_DWAT = 7;
  localparam int C_DIB  = 8;
  localparam int C_WAT  = 9;
  localparam int C_FETCH_ADDRESS_ERROR = 10;
  localparam int C_TLB_FETCH_MISS = 11;
  localparam int C_XI   = 12;
  localparam int C_IBE  = 13;
  // Register map of the plain register port
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_CAUSE  = 4'h1;
  localparam logic [3:0]  ADDR_DEBUG  = 4'h2;
  localparam logic [3:0]  ADDR_EPEND  = 4'h3;
  localparam logic [3:0]  ADDR_EMASK  = 4'h4;
  localparam logic [3:0]  ADDR_EXCEPTION_BASE_ADDRESS  = 4'h5;
  localparam logic [3:0]  ADDR_DCTRL  = 4'h6;
  localparam logic [3:0]  ADDR_TARGET = 4'h7;
  // Status bit positions
  localparam int ST_ERL  = 0;
  localparam int ST_EXL  = 1;
  localparam int ST_NMI  = 2;
  localparam int ST_SR   = 3;
  localparam int ST_MCHK = 4;
  localparam int ST_WP   = 5;
  localparam int ST_BEV  = 6;
  localparam int ST_IPL  = 8;
  // Debug status bit positions
  localparam int DB_DSS  = 0;
  localparam int DB_DEBUG_INTERRUPT = 1;
  localparam int DB_DIB  = 2;
  localparam int DC_BRK  = 0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TAKE  = 3'b010,
    ST_HOLD  = 3'b100
  } disp_state_t;
endpackage
`default_nettype wire

// ---- core/exc_rank.sv ----
// Fixed-priority picker over the pending exception causes
`default_nettype none
module exc_rank #(
  parameter int N = 14
) (
  input  wire logic [N-1:0] pending,
  output logic      [N-1:0] grant
);
  logic [N:0] seen;
  // Lowest index wins; each stage blocks all lower-ranked causes
  assign seen[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_rank
      assign grant[i]  = pending[i] & ~seen[i];
      assign seen[i+1] = seen[i] | pending[i];
    end
  endgenerate
endmodule // exc_rank
`default_nettype wire

// ---- core/exc_sync.sv ----
// Two-flop synchroniser for pin-level inputs
`default_nettype none
module exc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;
  // First stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // exc_sync
`default_nettype wire

// ---- core/exc_prioritizer.sv ----
// Exception ranking, dispatch and status recording for the core
// How it works
// RL1 - Causes ranked reset first, fetch bus error last
// RL2 - Reset: reset vector, boot select, error level
// RL3 - Soft reset: also sets soft reset flag
// RL4 - Single step: debug vector, single step bit
// RL5 - Debug interrupt from pin or break bit
// RL6 - NMI: reset vector, boot, nmi, error level
// RL7 - Machine check: general vector, flags, code 18h
// RL8 - Interrupt: priority level, code zero, own vector
// RL9 - Deferred watch: general vector, pending, code 17h
// RL10 - Instruction break: debug vector, break bit
// RL11 - Watch fetch: general vector, exl, code 17h
// RL12 - Address error: general vector, exl, code 04h
// RL13 - TLB miss: code 2, vector by exl
// RL14 - Execute inhibit: general vector, exl, code 14h
// RL15 - Bus error: general vector, exl, code 06h
// RL16 - Only top cause taken, code recorded
`default_nettype none
module exc_prioritizer
  import exc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        master_clear_n,
  input  wire logic        nmi_pin,
  input  wire logic        external_debug_request_input,
  input  wire logic        soft_reset_req,
  input  wire logic        debug_single_step_req,
  input  wire logic        tlb_write_conflict,
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_level,
  input  wire logic [31:0] irq_vector,
  input  wire logic        watch_deferred,
  input  wire logic        debug_break_match,
  input  wire logic        watch_fetch_hit,
  input  wire logic        fetch_address_error,
  input  wire logic        tlb_fetch_miss,
  input  wire logic        execute_inhibit_hit,
  input  wire logic        instruction_bus_error,
  input  wire logic        eret,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  output logic             exc_take,
  output logic      [31:0] exc_target,
  output logic      [4:0]  exception_cause_code,
  output logic             irq_out
);
  import exc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  logic [2:0] pin_sync;
  logic       master_clear_pin_n_s;
  logic       nmi_s;
  logic       dbg_pin_s;
  exc_sync #(.W(3)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({~master_clear_n, nmi_pin, external_debug_request_input}),
    .dout   (pin_sync)
  );
  assign master_clear_pin_n_s  = ~pin_sync[2];
  assign nmi_s     = pin_sync[1];
  assign dbg_pin_s = pin_sync[0];

  // ************************************************************
  // Registers and power-on state
  // ************************************************************
  logic [15:0]     status;
  logic [4:0]      cause_q;
  logic [2:0]      debug_status;
  logic [NUM_CAUSES-1:0] ev_pend;
  logic [NUM_CAUSES-1:0] ev_mask;
  logic [31:0]     exception_base_address;
  logic [31:0]     target_q;
  logic            debug_control_register;
  logic            por_pending;
  logic            nmi_prev;

  // ************************************************************
  // Cause collection and ranking
  // ************************************************************
  logic [NUM_CAUSES-1:0] pending;
  logic [NUM_CAUSES-1:0] grant;
  logic                  nmi_rise;
  assign nmi_rise = nmi_s & ~nmi_prev;

  // RL5 debug interrupt from pin or software break bit
  always_comb begin
    pending         = '0;
    pending[C_RST]  = por_pending | ~master_clear_pin_n_s;
    pending[C_SRST] = soft_reset_req;
    pending[C_DSS]  = debug_single_step_req;
    pending[C_DEBUG_INTERRUPT] = dbg_pin_s | debug_control_register;
    pending[C_NMI]  = nmi_rise;
    pending[C_MCHK] = tlb_write_conflict;
    pending[C_INT]  = irq_req;
    pending[C_DWAT] = watch_deferred;
    pending[C_DIB]  = debug_break_match;
    pending[C_WAT]  = watch_fetch_hit;
    pending[C_FETCH_ADDRESS_ERROR] = fetch_address_error;
    pending[C_TLB_FETCH_MISS] = tlb_fetch_miss;
    pending[C_XI]   = execute_inhibit_hit;
    pending[C_IBE]  = instruction_bus_error;
  end

  // RL1 fixed rank, lowest index highest
  exc_rank #(.N(NUM_CAUSES)) u_rank (
    .pending (pending),
    .grant   (grant)
  );

  // ************************************************************
  // Target, code and status update for the granted cause
  // ************************************************************
  logic [31:0] next_target;
  logic [4:0]  next_code;
  logic        code_valid;
  logic [31:0] general_vec;
  assign general_vec = exception_base_address + GENERAL_OFS;

  // RL16 one winner; code only where defined
  always_comb begin
    next_target = general_vec;
    next_code   = cause_q;
    code_valid  = 1'b0;
    if (grant[C_RST] | grant[C_SRST] | grant[C_NMI]) begin
      next_target = RESET_VECTOR;
    end else if (grant[C_DSS] | grant[C_DEBUG_INTERRUPT] | grant[C_DIB]) begin
      next_target = DEBUG_VECTOR;
    end else if (grant[C_MCHK]) begin
      next_code  = CODE_MCHK;
      code_valid = 1'b1;
    end else if (grant[C_INT]) begin
      // RL8 vector comes from the interrupt controller
      next_target = irq_vector;
      next_code   = CODE_INT;
      code_valid  = 1'b1;
    end else if (grant[C_DWAT] | grant[C_WAT]) begin
      next_code  = CODE_WATCH;
      code_valid = 1'b1;
    end else if (grant[C_FETCH_ADDRESS_ERROR]) begin
      next_code  = CODE_FETCH_ADDRESS_ERROR;
      code_valid = 1'b1;
    end else if (grant[C_TLB_FETCH_MISS]) begin
      // RL13 vector depends on exl
      next_target = status[ST_EXL] ? general_vec : exception_base_address;
      next_code   = CODE_TLB_FETCH_MISS;
      code_valid  = 1'b1;
    end else if (grant[C_XI]) begin
      next_code  = CODE_XI;
      code_valid = 1'b1;
    end else if (grant[C_IBE]) begin
      next_code  = CODE_IBE;
      code_valid = 1'b1;
    end
  end

  // Power-on reset is taken as an exception on the first clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_pending <= 1'b1;
      nmi_prev    <= 1'b0;
    end else begin
      por_pending <= 1'b0;
      nmi_prev    <= nmi_s;
    end
  end

  // Dispatch outputs registered one cycle after the cause
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exc_take             <= 1'b0;
      exc_target           <= '0;
      target_q             <= '0;
      exception_cause_code <= '0;
      cause_q              <= '0;
    end else begin
      exc_take <= |pending;
      if (|pending) begin
        exc_target <= next_target;
        target_q   <= next_target;
      end
      if (code_valid) begin
        exception_cause_code <= next_code;
        cause_q              <= next_code;
      end
    end
  end

  // Status bits per cause; eret clears exl or erl
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else if (grant[C_RST]) begin
      // RL2 boot select and error level
      status             <= '0;
      status[ST_BEV]     <= 1'b1;
      status[ST_ERL]     <= 1'b1;
    end else if (grant[C_SRST]) begin
      // RL3 soft reset adds its flag
      status[ST_BEV] <= 1'b1;
      status[ST_SR]  <= 1'b1;
      status[ST_ERL] <= 1'b1;
    end else if (grant[C_NMI]) begin
      // RL6 nmi flag with boot and error level
      status[ST_BEV] <= 1'b1;
      status[ST_NMI] <= 1'b1;
      status[ST_ERL] <= 1'b1;
    end else if (grant[C_MCHK]) begin
      // RL7 machine check and exl
      status[ST_MCHK] <= 1'b1;
      status[ST_EXL]  <= 1'b1;
    end else if (grant[C_INT]) begin
      // RL8 priority level updated
      status[ST_IPL+:3] <= irq_level;
    end else if (grant[C_DWAT]) begin
      // RL9 watch pending and exl
      status[ST_WP]  <= 1'b1;
      status[ST_EXL] <= 1'b1;
    end else if (grant[C_WAT] | grant[C_FETCH_ADDRESS_ERROR] | grant[C_XI] | grant[C_IBE]) begin
      // RL11 RL12 RL14 RL15 exl set
      status[ST_EXL] <= 1'b1;
    end else if (~|grant && reg_we && reg_addr == ADDR_STATUS) begin // Any cause wins
      status <= reg_wdata[15:0];
    end else if (~|grant && eret) begin
      if (status[ST_ERL]) begin
        status[ST_ERL] <= 1'b0;
      end else begin
        status[ST_EXL] <= 1'b0;
      end
    end
  end

  // Debug status leaves ordinary status alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_status <= '0;
    end else begin
      // RL4 single step bit
      if (grant[C_DSS]) begin
        debug_status <= 3'b001 << DB_DSS;
      // RL5 debug interrupt bit
      end else if (grant[C_DEBUG_INTERRUPT]) begin
        debug_status <= 3'b001 << DB_DEBUG_INTERRUPT;
      // RL10 instruction break bit
      end else if (grant[C_DIB]) begin
        debug_status <= 3'b001 << DB_DIB;
      end else if (reg_we && reg_addr == ADDR_DEBUG) begin
        debug_status <= reg_wdata[2:0];
      end
    end
  end

  // Break request bit clears once its interrupt is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_control_register <= 1'b0;
    end else if (reg_we && reg_addr == ADDR_DCTRL) begin
      debug_control_register <= reg_wdata[DC_BRK];
    end else if (grant[C_DEBUG_INTERRUPT]) begin
      debug_control_register <= 1'b0;
    end
  end

  // ************************************************************
  // Event flags, mask and interrupt output
  // ************************************************************
  logic rd_pend;
  assign rd_pend = reg_re && (reg_addr == ADDR_EPEND);

  // Set wins over the read-clear so no event is lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_pend <= '0;
    end else begin
      ev_pend <= (rd_pend ? '0 : ev_pend) | grant;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_mask                <= '0;
      exception_base_address <= EXCEPTION_BASE_ADDRESS_RESET;
    end else if (reg_we && reg_addr == ADDR_EMASK) begin
      ev_mask <= reg_wdata[NUM_CAUSES-1:0];
    end else if (reg_we && reg_addr == ADDR_EXCEPTION_BASE_ADDRESS) begin
      exception_base_address <= {reg_wdata[31:12], 12'h000};
    end
  end

  // Registered level interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((rd_pend ? '0 : ev_pend) | grant) & ev_mask);
    end
  end

  // ************************************************************
  // Register read port, data one cycle after strobe
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {16'h0000, status};
      end else if (reg_addr == ADDR_CAUSE) begin
        reg_rdata <= {25'h0, cause_q, 2'h0};
      end else if (reg_addr == ADDR_DEBUG) begin
        reg_rdata <= {29'h0, debug_status};
      end else if (reg_addr == ADDR_EPEND) begin
        reg_rdata <= {18'h0, ev_pend};
      end else if (reg_addr == ADDR_EMASK) begin
        reg_rdata <= {18'h0, ev_mask};
      end else if (reg_addr == ADDR_EXCEPTION_BASE_ADDRESS) begin
        reg_rdata <= exception_base_address;
      end else if (reg_addr == ADDR_DCTRL) begin
        reg_rdata <= {31'h0, debug_control_register};
      end else if (reg_addr == ADDR_TARGET) begin
        reg_rdata <= target_q;
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_reset_vector: assert property (grant[C_RST] |=> exc_take && exc_target == RESET_VECTOR // RL2
    && status[ST_BEV] && status[ST_ERL]) else $error("reset dispatch wrong");
  a_soft_reset: assert property (grant[C_SRST] |=> status[ST_SR] && status[ST_BEV] // RL3
    && status[ST_ERL] && exc_target == RESET_VECTOR) else $error("soft reset flags wrong");
  a_single_step: assert property (grant[C_DSS] |=> debug_status[DB_DSS] // RL4
    && exc_target == DEBUG_VECTOR && $stable(status)) else $error("single step dispatch wrong");
  a_debug_int: assert property (grant[C_DEBUG_INTERRUPT] |=> debug_status[DB_DEBUG_INTERRUPT] // RL5
    && !debug_control_register) else $error("debug interrupt dispatch wrong");
  a_nmi_flags: assert property (grant[C_NMI] |=> status[ST_NMI] && status[ST_ERL] // RL6
    && status[ST_BEV] && exc_target == RESET_VECTOR) else $error("nmi flags wrong");
  a_mchk_code: assert property (grant[C_MCHK] |=> exception_cause_code == CODE_MCHK // RL7
    && status[ST_MCHK] && status[ST_EXL]) else $error("machine check code wrong");
  a_int_level: assert property (grant[C_INT] |=> exception_cause_code == CODE_INT // RL8
    && status[ST_IPL+:3] == $past(irq_level)) else $error("interrupt level not recorded");
  a_dwatch_wp: assert property (grant[C_DWAT] |=> status[ST_WP] // RL9
    && exception_cause_code == CODE_WATCH) else $error("deferred watch wrong");
  a_dib_vector: assert property (grant[C_DIB] |=> debug_status[DB_DIB] // RL10
    && exc_target == DEBUG_VECTOR) else $error("instruction break wrong");
  a_tlb_fetch_miss_vector: assert property (grant[C_TLB_FETCH_MISS] && !status[ST_EXL] // RL13
    |=> exc_target == $past(exception_base_address)) else $error("tlb miss vector wrong");
  a_ibe_code: assert property (grant[C_IBE] |=> exception_cause_code == CODE_IBE // RL15
    && status[ST_EXL]) else $error("bus error code wrong");
  a_single_grant: assert property ($onehot0(grant) // RL16
    && ((|pending) == (|grant))) else $error("more than one cause taken");
endmodule // exc_prioritizer
`default_nettype wire

// ---- tb/exc_far_end.sv ----
// Far-side model: pipeline, interrupt controller, debug unit and TLB cause lines
`default_nettype none
module exc_far_end
  import exc_pkg::*;
(
  input  wire logic [13:0] cause_req,
  output logic      [13:0] drive
);
  // ****************************************
  // Cause lines as the far side drives them
  // ****************************************
  // clear pin is active low, so only its line is inverted
  // debug request and NMI pins high while asserted
  assign drive = cause_req ^ (14'h1 << C_RST);
endmodule // exc_far_end
`default_nettype wire

// ---- tb/test_cpu_exception_prioritizer.sv ----
// Self-checking bench for the exception prioritizer
`default_nettype none
module test_cpu_exception_prioritizer
  import exc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Causes that reach the core on its own clock, no synchroniser
  localparam logic [13:0] SYNC = 14'h3FE6;
  logic        clk, arst_n, eret_r, reg_we, reg_re, exc_take, irq_out;
  logic [13:0] req, drive;
  logic [2:0]  irq_lvl;
  logic [3:0]  reg_addr;
  logic [4:0]  code, m_code;
  logic [31:0] irq_vec, reg_wdata, reg_rdata, exc_target, m_st, m_db, m_tgt, m_eb;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  exc_far_end far (.cause_req(req), .drive(drive));
  exc_prioritizer dut (
    .clk(clk), .arst_n(arst_n), .master_clear_n(drive[C_RST]), .nmi_pin(drive[C_NMI]),
    .external_debug_request_input(drive[C_DEBUG_INTERRUPT]), .soft_reset_req(drive[C_SRST]),
    .debug_single_step_req(drive[C_DSS]), .tlb_write_conflict(drive[C_MCHK]),
    .irq_req(drive[C_INT]), .irq_level(irq_lvl), .irq_vector(irq_vec),
    .watch_deferred(drive[C_DWAT]), .debug_break_match(drive[C_DIB]),
    .watch_fetch_hit(drive[C_WAT]), .fetch_address_error(drive[C_FETCH_ADDRESS_ERROR]),
    .tlb_fetch_miss(drive[C_TLB_FETCH_MISS]), .execute_inhibit_hit(drive[C_XI]),
    .instruction_bus_error(drive[C_IBE]), .eret(eret_r), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .exc_take(exc_take), .exc_target(exc_target), .exception_cause_code(code),
    .irq_out(irq_out)
  );

  // ****************************************
  // Bus, compare and reference model
  // ****************************************
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk_disp(input logic [31:0] t, input logic [4:0] c);
    cmp_count++;
    if (exc_take !== 1'b1 || exc_target !== t || code !== c) begin
      n_errors++;
      $display("BAD %0t got %h %h %h exp 1 %h %h", $time, exc_take, exc_target, code, t, c);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clk) reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk) begin
      reg_re <= 1'b1;
      reg_addr <= a;
    end
    @(posedge clk) reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Expected target, status, debug and code of one taken cause
  task automatic model_take(input int i, output logic [31:0] t);
    t = m_eb + GENERAL_OFS;
    case (i)
      C_RST, C_SRST, C_NMI: begin
        t = RESET_VECTOR;
        if (i == C_RST) m_st = '0;
        m_st[ST_BEV] = 1'b1;
        m_st[ST_ERL] = 1'b1;
        if (i == C_SRST) m_st[ST_SR] = 1'b1;
        if (i == C_NMI) m_st[ST_NMI] = 1'b1;
      end
      C_DSS:  begin t = DEBUG_VECTOR; m_db = 32'h1 << DB_DSS; end
      C_DEBUG_INTERRUPT: begin t = DEBUG_VECTOR; m_db = 32'h1 << DB_DEBUG_INTERRUPT; end
      C_DIB:  begin t = DEBUG_VECTOR; m_db = 32'h1 << DB_DIB; end
      C_INT:  begin t = irq_vec; m_st[10:8] = irq_lvl; m_code = CODE_INT; end
      C_TLB_FETCH_MISS: begin if (!m_st[ST_EXL]) t = m_eb; m_code = CODE_TLB_FETCH_MISS; end
      default: begin
        m_st[ST_EXL] = 1'b1;
        if (i == C_MCHK) m_st[ST_MCHK] = 1'b1;
        if (i == C_DWAT) m_st[ST_WP] = 1'b1;
        m_code = (i == C_MCHK) ? CODE_MCHK : (i == C_FETCH_ADDRESS_ERROR) ? CODE_FETCH_ADDRESS_ERROR :
                 (i == C_XI) ? CODE_XI : (i == C_IBE) ? CODE_IBE : CODE_WATCH;
      end
    endcase
    m_tgt = t;
  endtask

  task automatic expect_v(input logic [13:0] v);
    logic [31:0] t;
    int i;
    i = 0;
    while (i < 14 && !v[i]) i++;
    if (i == 14) chk_reg({31'h0, exc_take}, 32'h0);
    else begin
      model_take(i, t);
      chk_disp(t, m_code);
    end
  endtask

  // Cause vectors back to back, one per cycle, each answered one cycle later
  task automatic burst(input logic [13:0] q[$]);
    @(posedge clk) begin
      req <= q[0];
      irq_lvl <= 3'($urandom);
      irq_vec <= $urandom;
    end
    for (int k = 0; k < q.size(); k++) begin
      @(posedge clk) req <= (k + 1 < q.size()) ? q[k + 1] : 14'h0;
      #1 expect_v(q[k]);
    end
  endtask

  // Pin causes pass a synchroniser, so wait a bounded window and count takes
  task automatic catch_take(input int idx, input int win);
    logic [31:0] t;
    int n;
    n = 0;
    repeat (win) begin
      @(posedge clk);
      #1 if (exc_take === 1'b1) begin
        n++;
        if (n == 1) begin
          model_take(idx, t);
          chk_disp(t, m_code);
        end
      end
    end
    chk_reg(n, 1);
  endtask

  task automatic pin(input int idx, input int hold);
    @(posedge clk) req[idx] <= 1'b1;
    fork
      begin
        repeat (hold) @(posedge clk);
        req[idx] <= 1'b0;
      end
    join_none
    catch_take(idx, hold + 8);
  endtask

  task automatic check_regs;
    logic [31:0] d;
    rd(ADDR_STATUS, d);
    chk_reg(d & 32'h7FF, m_st);
    rd(ADDR_DEBUG, d);
    chk_reg(d, m_db);
    rd(ADDR_CAUSE, d);
    chk_reg((d >> 2) & 32'h1F, {27'h0, m_code});
    rd(ADDR_TARGET, d);
    chk_reg(d, m_tgt);
  endtask

  task automatic do_eret;
    @(posedge clk) eret_r <= 1'b1;
    @(posedge clk) eret_r <= 1'b0;
    if (m_st[ST_ERL]) m_st[ST_ERL] = 1'b0;
    else m_st[ST_EXL] = 1'b0;
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #300_000;
    n_errors++;
    final_report;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [31:0] d, e;
    logic [13:0] q[$];
    clk = 1'b0; arst_n = 1'b0; req = '0; eret_r = 1'b0; irq_lvl = '0; irq_vec = '0;
    reg_addr = '0; reg_wdata = '0; reg_we = 1'b0; reg_re = 1'b0;
    m_st = '0; m_db = '0; m_code = '0; m_tgt = '0; m_eb = EXCEPTION_BASE_ADDRESS_RESET;
    void'($urandom(32'hE3F23130));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    catch_take(C_RST, 6);
    check_regs;
    $display("done power-on reset");
    // Base register keeps its low 12 bits zero; unmapped places read zero
    rd(ADDR_EXCEPTION_BASE_ADDRESS, d);
    chk_reg(d, EXCEPTION_BASE_ADDRESS_RESET);
    e = 32'h8000_0000 | ($urandom & 32'h3FFF_F000);
    wr(ADDR_EXCEPTION_BASE_ADDRESS, e | ($urandom & 32'hFFF));
    rd(ADDR_EXCEPTION_BASE_ADDRESS, d);
    chk_reg(d, e);
    m_eb = e;
    wr(4'hA, $urandom);
    rd(4'hA, d);
    chk_reg(d, 32'h0);
    $display("done registers");
    for (int i = 1; i < NUM_CAUSES; i++) if (SYNC[i]) begin
      burst('{14'h1 << i});
      check_regs;
    end
    // Fetch miss with the exception level clear goes to the bare base
    do_eret;
    do_eret;
    burst('{14'h1 << C_TLB_FETCH_MISS});
    check_regs;
    $display("done single causes");
    repeat (12) begin
      q = {};
      repeat (4) q.push_back(14'($urandom) & SYNC);
      burst(q);
    end
    $display("done ranking");
    // Sticky flags, mask and interrupt level
    rd(ADDR_EPEND, d);
    wr(ADDR_EMASK, 32'h1 << C_WAT);
    burst('{14'h1 << C_FETCH_ADDRESS_ERROR});
    repeat (2) @(posedge clk);
    #1 chk_reg({31'h0, irq_out}, 32'h0);
    rd(ADDR_EPEND, d);
    chk_reg(d, 32'h1 << C_FETCH_ADDRESS_ERROR);
    burst('{14'h1 << C_WAT});
    repeat (2) @(posedge clk);
    #1 chk_reg({31'h0, irq_out}, 32'h1);
    rd(ADDR_EPEND, d);
    chk_reg(d, 32'h1 << C_WAT);
    repeat (2) @(posedge clk);
    #1 chk_reg({31'h0, irq_out}, 32'h0);
    rd(ADDR_EPEND, d);
    chk_reg(d, 32'h0);
    $display("done events");
    // Debug request by pin and by break bit, then edge-taken NMI, then clear pin
    pin(C_DEBUG_INTERRUPT, 1);
    wr(ADDR_DCTRL, 32'h1 << DC_BRK);
    catch_take(C_DEBUG_INTERRUPT, 8);
    rd(ADDR_DCTRL, d);
    chk_reg(d & 32'h1, 32'h0);
    pin(C_NMI, 5);
    check_regs;
    pin(C_RST, 1);
    check_regs;
    $display("done pins");
    final_report;
  end
endmodule // test_cpu_exception_prioritizer
`default_nettype wire
